//--- src/ppp_defines.svh
// Offsets, field positions, reset values and timing counts of the printer port.
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH

`define PPP_ADDR_DATA      2'h0
`define PPP_ADDR_STATUS    2'h1
`define PPP_ADDR_CTRL      2'h2

`define PPP_CTRL_STROBE    0
`define PPP_CTRL_AUTOLF    1
`define PPP_CTRL_INIT      2
`define PPP_CTRL_SELIN     3
`define PPP_CTRL_AUTOSTB   4

`define PPP_STAT_IRQ       2
`define PPP_STAT_FAULT_N   3
`define PPP_STAT_SELECTED  4
`define PPP_STAT_PAPER     5
`define PPP_STAT_ACK_N     6
`define PPP_STAT_BUSY      7

`define PPP_CTRL_RESET     8'h00
`define PPP_DATA_RESET     8'h00
`define PPP_SYNC_WIDTH     19

`define PPP_CLK_PERIOD_NS  8
`define PPP_SETUP_NS       1000
`define PPP_STROBE_NS      1000
`define PPP_SETUP_CYC      ((`PPP_SETUP_NS + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)
`define PPP_STROBE_CYC     ((`PPP_STROBE_NS + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)

`endif

//--- src/ppp_pkg.sv
// Types shared by the printer port design.
`default_nettype none
package ppp_pkg;
	typedef logic [7:0] ppp_byte_t;
	typedef enum logic [1:0] {
		PPP_ST_IDLE,
		PPP_ST_SETUP,
		PPP_ST_PULSE
	} ppp_state_e;
endpackage
`default_nettype wire

//--- src/ppp_pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`default_nettype none
module ppp_pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] meta_q;

	// Pins have pull-ups, so the idle level of every synchronised input is high.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge core_clk) begin
			if (reset) begin
				meta_q[i]   <= 1'b1;
				pin_sync[i] <= 1'b1;
			end else begin
				meta_q[i]   <= pin_in[i];
				pin_sync[i] <= meta_q[i];
			end
		end
	end
endmodule
`default_nettype wire

//--- src/ppp_port.sv
// Parallel printer port: host access, data bus, control lines, status and interrupt.
`include "ppp_defines.svh"
`default_nettype none
module ppp_port
	import ppp_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       printer_port_select_n,
	input  wire logic [1:0] cpu_addr,
	input  wire logic       cpu_wr,
	input  wire logic       cpu_rd,
	input  wire logic [7:0] cpu_wdata,
	output logic      [7:0] cpu_rdata,
	output logic            strobe_busy,
	input  wire logic       port_direction_select,
	input  wire logic       irq_mode_select,
	input  wire logic [7:0] printer_data_bus_in,
	output logic      [7:0] printer_data_bus_out,
	output logic      [7:0] printer_data_bus_oe,
	input  wire logic [3:0] ctrl_line_in,
	output logic      [3:0] ctrl_line_out,
	output logic      [3:0] ctrl_line_oe,
	input  wire logic       fault_n,
	input  wire logic       printer_selected,
	input  wire logic       busy,
	input  wire logic       paper_out,
	input  wire logic       ack_n,
	output logic            printer_irq_n
);
	localparam int SETUP_CYC  = `PPP_SETUP_CYC;
	localparam int STROBE_CYC = `PPP_STROBE_CYC;

	logic [`PPP_SYNC_WIDTH-1:0] pins_s;
	logic [7:0]                 data_s;
	logic [3:0]                 ctrl_s;
	logic                       dir_s;
	logic                       mode_s;
	logic                       busy_s;
	logic                       ack_s;
	logic                       paper_s;
	logic                       sel_s;
	logic                       fault_s;
	ppp_byte_t                  data_q;
	ppp_byte_t                  ctrl_q;
	ppp_byte_t                  status_w;
	ppp_state_e                 state_q;
	logic [7:0]                 cnt_q;
	logic                       ack_prev_q;
	logic                       irq_latch_q;
	logic                       host_en;
	logic                       wr_data;
	logic                       wr_ctrl;
	logic                       rd_status;
	logic                       ack_fall;
	logic                       pulse_on;

	ppp_pin_sync #(
		.WIDTH(`PPP_SYNC_WIDTH)
	) u_sync (
		.core_clk(core_clk),
		.reset   (reset),
		.pin_in  ({printer_data_bus_in, ctrl_line_in, port_direction_select, irq_mode_select,
			busy, ack_n, paper_out, printer_selected, fault_n}),
		.pin_sync(pins_s)
	);

	assign data_s  = pins_s[18:11];
	assign ctrl_s  = pins_s[10:7];
	assign dir_s   = pins_s[6];
	assign mode_s  = pins_s[5];
	assign busy_s  = pins_s[4];
	assign ack_s   = pins_s[3];
	assign paper_s = pins_s[2];
	assign sel_s   = pins_s[1];
	assign fault_s = pins_s[0];

	assign host_en   = !printer_port_select_n;
	assign wr_data   = host_en && cpu_wr && (cpu_addr == `PPP_ADDR_DATA);
	assign wr_ctrl   = host_en && cpu_wr && (cpu_addr == `PPP_ADDR_CTRL);
	assign rd_status = host_en && cpu_rd && (cpu_addr == `PPP_ADDR_STATUS);

	// Status byte: pin levels as seen by the printer cable, plus the latched interrupt.
	always_comb begin
		status_w                     = 8'h00;
		status_w[`PPP_STAT_BUSY]     = busy_s;
		status_w[`PPP_STAT_ACK_N]    = ack_s;
		status_w[`PPP_STAT_PAPER]    = paper_s;
		status_w[`PPP_STAT_SELECTED] = sel_s;
		status_w[`PPP_STAT_FAULT_N]  = fault_s;
		status_w[`PPP_STAT_IRQ]      = irq_latch_q;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			data_q <= `PPP_DATA_RESET;
		end else if (wr_data) begin
			data_q <= cpu_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_q <= `PPP_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= {3'h0, cpu_wdata[4:0]};
		end
	end

	// Reads of the data address return the cable in input mode, the latch otherwise.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cpu_rdata <= 8'h00;
		end else if (host_en && cpu_rd) begin
			case (cpu_addr)
				`PPP_ADDR_DATA:   cpu_rdata <= dir_s ? data_s : data_q;
				`PPP_ADDR_STATUS: cpu_rdata <= status_w;
				`PPP_ADDR_CTRL:   cpu_rdata <= {3'h0, ctrl_q[`PPP_CTRL_AUTOSTB], ctrl_s};
				default:          cpu_rdata <= 8'h00;
			endcase
		end
	end

	// Automatic strobe: setup time after a data write, then a timed low pulse.
	// A busy printer holds the strobe back, so a byte is never offered it cannot take.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= PPP_ST_IDLE;
			cnt_q   <= 8'h00;
		end else begin
			case (state_q)
				PPP_ST_IDLE: begin
					if (wr_data && ctrl_q[`PPP_CTRL_AUTOSTB] && !dir_s) begin
						state_q <= PPP_ST_SETUP;
						cnt_q   <= 8'(SETUP_CYC - 1);
					end
				end
				PPP_ST_SETUP: begin
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (!busy_s) begin
						state_q <= PPP_ST_PULSE;
						cnt_q   <= 8'(STROBE_CYC - 1);
					end
				end
				PPP_ST_PULSE: begin
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else begin
						state_q <= PPP_ST_IDLE;
					end
				end
				default: begin
					state_q <= PPP_ST_IDLE;
					cnt_q   <= 8'h00;
				end
			endcase
		end
	end

	assign pulse_on    = (state_q == PPP_ST_PULSE);
	assign strobe_busy = (state_q != PPP_ST_IDLE);

	// Pins: open-drain lines only ever pull low; a released line reads back as GPIO input.
	assign printer_data_bus_out = data_q;
	assign printer_data_bus_oe  = dir_s ? 8'h00 : 8'hFF;
	assign ctrl_line_out        = 4'h0;
	assign ctrl_line_oe[`PPP_CTRL_STROBE] = ctrl_q[`PPP_CTRL_STROBE] || pulse_on;
	assign ctrl_line_oe[`PPP_CTRL_AUTOLF] = ctrl_q[`PPP_CTRL_AUTOLF];
	assign ctrl_line_oe[`PPP_CTRL_INIT]   = ctrl_q[`PPP_CTRL_INIT];
	assign ctrl_line_oe[`PPP_CTRL_SELIN]  = ctrl_q[`PPP_CTRL_SELIN];

	// Interrupt. The follow mode lags the pin by the synchroniser and one output flop.
	assign ack_fall = ack_prev_q && !ack_s;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_prev_q  <= 1'b1;
			irq_latch_q <= 1'b0;
		end else begin
			ack_prev_q <= ack_s;
			if (ack_fall && mode_s) begin
				irq_latch_q <= 1'b1;
			end else if (rd_status || !mode_s) begin
				irq_latch_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			printer_irq_n <= 1'b1;
		end else if (!mode_s) begin
			printer_irq_n <= ack_s;
		end else begin
			printer_irq_n <= !(irq_latch_q || (ack_fall && mode_s));
		end
	end

	// Setup cycles elapsed, saturating. Too long for a repetition, so a counter measures it.
	logic [7:0] setup_age_q;

	always_ff @(posedge core_clk) begin
		if (reset || state_q != PPP_ST_SETUP) begin
			setup_age_q <= 8'h00;
		end else if (setup_age_q != 8'hFF) begin
			setup_age_q <= setup_age_q + 8'h01;
		end
	end

	sequence s_auto_write;
		wr_data && ctrl_q[`PPP_CTRL_AUTOSTB] && !dir_s && state_q == PPP_ST_IDLE;
	endsequence

	sequence s_setup_done;
		state_q == PPP_ST_SETUP && cnt_q == 8'h00 && !busy_s;
	endsequence

	AST_SETUP_ENTRY: assert property (@(posedge core_clk) disable iff (reset)
		s_auto_write |=> strobe_busy && state_q == PPP_ST_SETUP)
		else $error("automatic strobe sequence not started by data write");

	AST_SETUP_LENGTH: assert property (@(posedge core_clk) disable iff (reset)
		$rose(pulse_on) |-> setup_age_q >= 8'(SETUP_CYC))
		else $error("strobe started before the setup time elapsed");

	AST_NO_WRITE_UNSELECTED: assert property (@(posedge core_clk) disable iff (reset)
		(printer_port_select_n && cpu_wr) |=> $stable(data_q) && $stable(ctrl_q))
		else $error("register changed without port select");

	AST_DATA_DRIVEN: assert property (@(posedge core_clk) disable iff (reset)
		(!dir_s && $past(wr_data)) |-> printer_data_bus_out == $past(cpu_wdata)
		&& printer_data_bus_oe == 8'hFF)
		else $error("written byte not driven in output mode");

	AST_INPUT_MODE: assert property (@(posedge core_clk) disable iff (reset)
		dir_s |-> printer_data_bus_oe == 8'h00)
		else $error("data bus driven in input mode");

	AST_STROBE_TIMING: assert property (@(posedge core_clk) disable iff (reset)
		s_setup_done |=> ctrl_line_oe[`PPP_CTRL_STROBE] && ctrl_line_out[`PPP_CTRL_STROBE] == 1'b0)
		else $error("strobe not asserted after setup time");

	AST_BUSY_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		(state_q == PPP_ST_SETUP && busy_s) |=> state_q != PPP_ST_PULSE)
		else $error("strobe started while printer busy");

	AST_CTRL_LINES: assert property (@(posedge core_clk) disable iff (reset)
		$past(wr_ctrl) |-> ctrl_line_oe[3:1] == $past(cpu_wdata[3:1]) && ctrl_line_out == 4'h0)
		else $error("open-drain control lines do not follow control write");

	AST_GPIO_READ: assert property (@(posedge core_clk) disable iff (reset)
		(host_en && cpu_rd && cpu_addr == `PPP_ADDR_CTRL) |=> cpu_rdata[3:0] == $past(ctrl_s))
		else $error("control line levels not readable");

	AST_IRQ_FOLLOW: assert property (@(posedge core_clk) disable iff (reset)
		(!mode_s ##1 !mode_s) |-> printer_irq_n == $past(ack_s))
		else $error("interrupt does not follow acknowledge");

	AST_IRQ_LATCH: assert property (@(posedge core_clk) disable iff (reset)
		(mode_s && irq_latch_q && !rd_status && !ack_s) [*2] |-> !printer_irq_n)
		else $error("latched interrupt released without status read");

	AST_IRQ_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
		(mode_s && rd_status && !ack_fall) ##1 (mode_s && !ack_fall) |=> printer_irq_n)
		else $error("status read does not release latched interrupt");
endmodule
`default_nettype wire

//--- dv/ppp_printer_model.sv
// Behavioural line printer answering each strobe that falls while it is not busy with busy and an acknowledge pulse.
`default_nettype none
module ppp_printer_model (
	input  wire logic       core_clk,
	input  wire logic       strobe_n,
	input  wire logic       init_n,
	input  wire logic       selin_n,
	input  wire logic [7:0] data,
	input  wire logic       err_req,
	input  wire logic       paper_req,
	input  wire logic       hold_busy,
	output logic            fault_n,
	output logic            printer_selected,
	output logic            busy,
	output logic            paper_out,
	output var logic        ack_n,
	output var logic  [7:0] last_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       strobe_q = 1'b1;
	logic       busy_q = 1'b0;
	logic [7:0] cnt_q = 8'h00;
	initial ack_n = 1'b1;
	initial last_byte = 8'h00;
	assign fault_n = ~err_req;
	assign printer_selected = ~selin_n;
	assign paper_out = paper_req;
	// A held request keeps the printer busy, so the port must stall its strobe.
	assign busy = busy_q | hold_busy;
	always @(posedge core_clk) begin
		strobe_q <= strobe_n;
		if (!init_n) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			ack_n <= 1'b1;
		end else if (strobe_q && !strobe_n && !busy) begin
			last_byte <= data;
			busy_q <= 1'b1;
			cnt_q <= 8'h10;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
			ack_n <= !(cnt_q inside {[8'h02:8'h04]});
			if (cnt_q == 8'h01) begin
				busy_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the printer port with a printer model on its far side.
`include "ppp_defines.svh"
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top
	import ppp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk, reset, sel_n, cpu_wr, cpu_rd, dir, mode, sbusy, irq_n;
	logic       err_req, paper_req, hold_busy, fault_n, sel, busy, paper, ack_n, fchk;
	logic [1:0] cpu_addr;
	logic [2:0] hist;
	logic [3:0] ctrl_oe, ctrl_out, lvl;
	logic [7:0] cpu_wdata, cpu_rdata, bus_out, bus_oe, tb_bus, bus_in, last_byte;
	ppp_byte_t  v, r;
	int         n_fail, tests_run, n;
	assign bus_in = (bus_out & bus_oe) | (tb_bus & ~bus_oe);
	assign lvl = ctrl_out | ~ctrl_oe;
	ppp_port i_dut (.core_clk(core_clk), .reset(reset), .printer_port_select_n(sel_n),
		.cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .strobe_busy(sbusy), .port_direction_select(dir),
		.irq_mode_select(mode), .printer_data_bus_in(bus_in), .printer_data_bus_out(bus_out),
		.printer_data_bus_oe(bus_oe), .ctrl_line_in(lvl), .ctrl_line_out(ctrl_out),
		.ctrl_line_oe(ctrl_oe), .fault_n(fault_n), .printer_selected(sel), .busy(busy),
		.paper_out(paper), .ack_n(ack_n), .printer_irq_n(irq_n));
	ppp_printer_model i_prn (.core_clk(core_clk), .strobe_n(lvl[0]), .init_n(lvl[2]),
		.selin_n(lvl[3]), .data(bus_out), .err_req(err_req), .paper_req(paper_req),
		.hold_busy(hold_busy), .fault_n(fault_n), .printer_selected(sel), .busy(busy),
		.paper_out(paper), .ack_n(ack_n), .last_byte(last_byte));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) hist <= {hist[1:0], ack_n};
	always @(negedge core_clk) if (fchk) `CHK(irq_n, hist[2])
	// Status byte expected from an idle printer with no irq latched.
	function automatic ppp_byte_t exp_status(input logic no_paper, input logic is_sel,
		input logic flt_n);
		return {2'b01, no_paper, is_sel, flt_n, 3'b000};
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input ppp_byte_t d, input logic s = 1'b0);
		@(negedge core_clk);
		sel_n = s;
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(negedge core_clk);
		cpu_wr = 1'b0;
		sel_n = 1'b1;
	endtask
	task automatic rd(input logic [1:0] a, output ppp_byte_t d);
		@(negedge core_clk);
		sel_n = 1'b0;
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge core_clk);
		cpu_rd = 1'b0;
		sel_n = 1'b1;
		d = cpu_rdata;
	endtask
	// Counts cycles until the strobe drive reaches the wanted level; a hang ends the run.
	task automatic wait_stb(input logic lv);
		n = 0;
		while (ctrl_oe[0] !== lv && n < 2000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 2000) begin
			n_fail++;
			summarize();
		end
	endtask
	initial begin
		{sel_n, reset} = 2'b11;
		{cpu_addr, cpu_wr, cpu_rd, cpu_wdata, dir, mode, fchk} = '0;
		{err_req, paper_req, hold_busy, tb_bus, n_fail, tests_run} = '0;
		void'($urandom(32'h0EB503AE));
		repeat (10) @(negedge core_clk);
		`CHK(bus_oe, 8'h00)
		`CHK(irq_n, 1'b1)
		reset = 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK(bus_oe, 8'hFF)
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			wr(2'h0, v);
			`CHK(bus_out, v)
			wr(2'h0, ~v, 1'b1);
			rd(2'h0, r);
			`CHK(r, v)
		end
		wr(2'h3, 8'hFF);
		rd(2'h3, r);
		`CHK(r, 8'h00)
		dir = 1'b1;
		tb_bus = 8'($urandom);
		repeat (3) @(negedge core_clk);
		`CHK(bus_oe, 8'h00)
		rd(2'h0, r);
		`CHK(r, tb_bus)
		dir = 1'b0;
		for (int i = 0; i < 16; i++) begin
			{err_req, paper_req} = 2'($urandom);
			wr(2'h2, 8'(i));
			`CHK(ctrl_oe, 4'(i))
			`CHK(ctrl_out, 4'h0)
			// A manual strobe makes the model busy; its acknowledge must end before status.
			repeat (24) @(negedge core_clk);
			rd(2'h2, r);
			`CHK(r, {4'h0, ~4'(i)})
			rd(2'h1, r);
			`CHK(r, exp_status(paper_req, i[3], ~err_req))
		end
		fchk = 1'b1;
		wr(2'h2, 8'h10);
		v = 8'($urandom);
		wr(2'h0, v);
		`CHK(sbusy, 1'b1)
		wait_stb(1'b1);
		`CHK(n, `PPP_SETUP_CYC)
		wait_stb(1'b0);
		`CHK(n, `PPP_STROBE_CYC)
		`CHK(sbusy, 1'b0)
		`CHK(last_byte, v)
		fchk = 1'b0;
		{mode, hold_busy} = 2'b11;
		wr(2'h0, ~v);
		repeat (300) @(negedge core_clk);
		`CHK(ctrl_oe[0], 1'b0)
		`CHK(sbusy, 1'b1)
		hold_busy = 1'b0;
		wait_stb(1'b1);
		wait_stb(1'b0);
		`CHK(last_byte, ~v)
		`CHK(irq_n, 1'b0)
		rd(2'h1, r);
		`CHK(r[2], 1'b1)
		repeat (2) @(negedge core_clk);
		`CHK(irq_n, 1'b1)
		rd(2'h1, r);
		`CHK(r[2], 1'b0)
		summarize();
	end
endmodule
`default_nettype wire
